// ### cancs_regs.vh
`ifndef CANCS_REGS_VH
`define CANCS_REGS_VH

// register port addresses
`define CANCS_ADDR_W 5
`define CANCS_ADDR_CMD 5'h01
`define CANCS_ADDR_STAT 5'h02

// command_port bit positions
`define CANCS_CMD_TX_REQ 0
`define CANCS_CMD_TX_ABORT 1
`define CANCS_CMD_RX_REL 2
`define CANCS_CMD_OVR_CLR 3
`define CANCS_CMD_SLEEP 4

// status_word bit positions
`define CANCS_ST_RX_AVAIL 0
`define CANCS_ST_OVERRUN 1
`define CANCS_ST_TXB_FREE 2
`define CANCS_ST_TX_DONE 3
`define CANCS_ST_RX_ACT 4
`define CANCS_ST_TX_ACT 5
`define CANCS_ST_ERR_WARN 6
`define CANCS_ST_BUS_OFF 7

// read values
`define CANCS_CMD_READ 8'hff
`define CANCS_UNMAPPED_READ 8'h00

// limits and counts
`define CANCS_ECNT_W 9
`define CANCS_WARN_LIMIT 9'h060
`define CANCS_BUSOFF_LIMIT 9'h0ff
`define CANCS_RECOVER_W 8
`define CANCS_RECOVER_FREES 8'h80
`define CANCS_BITCNT_W 4
`define CANCS_BUSFREE_BITS 4'hb
`define CANCS_HOST_CLOCK_OUTPUT_BITS 4'hf
`define CANCS_QCNT_W 6
`define CANCS_QCNT_MAX 6'h3f

`endif

// ### cancs_busfree.v
`include "cancs_regs.vh"

module cancs_busfree (
	input wire clock_i,
	input wire rstn_i,
	input wire bit_tick_i,
	input wire rx_bit_i,
	output reg idle_o,
	output reg free_o
);

reg [`CANCS_BITCNT_W-1:0] cnt_ff;
reg [`CANCS_BITCNT_W-1:0] nxt_cnt;
wire last_bit;

assign last_bit = (cnt_ff == `CANCS_BUSFREE_BITS - 4'h1);

// counter restarts after each bus-free so successive occurrences can be counted
always @* begin
	nxt_cnt = cnt_ff;
	// any dominant level restarts the run, even between bit ticks
	if (!rx_bit_i)
		nxt_cnt = 4'h0;
	else if (bit_tick_i) begin
		if (last_bit)
			nxt_cnt = 4'h0;
		else
			nxt_cnt = cnt_ff + 4'h1;
	end
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		cnt_ff <= 4'h0;
		idle_o <= 1'b0;
		free_o <= 1'b0;
	end else begin
		cnt_ff <= nxt_cnt;
		free_o <= bit_tick_i && rx_bit_i && last_bit;
		if (!rx_bit_i)
			idle_o <= 1'b0;
		else if (bit_tick_i && last_bit)
			idle_o <= 1'b1;
	end
end

endmodule

// ### cancs_core.v
// Chosen here: the strobed register port.
`include "cancs_regs.vh"

module cancs_core (
	input wire clock_i,
	input wire rstn_i,
	input wire [`CANCS_ADDR_W-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire bit_tick_i,
	input wire quantum_tick_i,
	input wire can_rx_i,
	input wire int_n_pin_i,
	input wire irq_pending_i,
	input wire rst_req_i,
	input wire eie_i,
	input wire rie_i,
	input wire oie_i,
	input wire [`CANCS_ECNT_W-1:0] tec_i,
	input wire [`CANCS_ECNT_W-1:0] rec_i,
	input wire tx_start_i,
	input wire tx_ok_i,
	input wire tx_active_i,
	input wire rx_active_i,
	input wire rx_store_i,
	input wire rx_drop_valid_i,
	input wire txb_wr_i,
	output reg txb_we_o,
	output reg tx_pend_o,
	output reg rx_release_o,
	output reg rx_hold_o,
	output reg rst_req_set_o,
	output reg err_cnt_clr_o,
	output reg wake_irq_o,
	output reg err_irq_o,
	output reg rx_irq_o,
	output reg ovr_irq_o,
	output reg sleep_o,
	output reg osc_en_o,
	output reg host_clock_output_o
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers and bus-free detection

localparam S_RUN = 3'b001;
localparam S_SLEEP = 3'b010;
localparam S_STOP = 3'b100;

reg rx_meta_ff, rx_sync_ff, int_meta_ff, int_sync_ff;
wire bus_idle, bus_free;

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		rx_meta_ff <= 1'b1;
		rx_sync_ff <= 1'b1;
		int_meta_ff <= 1'b1;
		int_sync_ff <= 1'b1;
	end else begin
		rx_meta_ff <= can_rx_i;
		rx_sync_ff <= rx_meta_ff;
		int_meta_ff <= int_n_pin_i;
		int_sync_ff <= int_meta_ff;
	end
end

cancs_busfree u_busfree (
	.clock_i(clock_i),
	.rstn_i(rstn_i),
	.bit_tick_i(bit_tick_i),
	.rx_bit_i(rx_sync_ff),
	.idle_o(bus_idle),
	.free_o(bus_free)
);

////////////////////////////////////////////////////////////////////////
// command decode; bits 7..5 are never looked at

wire cmd_wr = wr_i && (addr_i == `CANCS_ADDR_CMD);
wire c_tr = cmd_wr && wdata_i[`CANCS_CMD_TX_REQ];
wire c_at = cmd_wr && wdata_i[`CANCS_CMD_TX_ABORT];
wire c_rrb = cmd_wr && wdata_i[`CANCS_CMD_RX_REL];
wire c_cdo = cmd_wr && wdata_i[`CANCS_CMD_OVR_CLR];
wire c_gts1 = cmd_wr && wdata_i[`CANCS_CMD_SLEEP];
wire c_gts0 = cmd_wr && !wdata_i[`CANCS_CMD_SLEEP];

////////////////////////////////////////////////////////////////////////
// transmit request, abort, completion and buffer lock

reg tx_pend_ff, tx_run_ff, tx_done_ff, txb_lock_ff;

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		tx_pend_ff <= 1'b0;
		tx_run_ff <= 1'b0;
		tx_done_ff <= 1'b1;
		txb_lock_ff <= 1'b0;
		txb_we_o <= 1'b0;
		tx_pend_o <= 1'b0;
	end else begin
		txb_we_o <= txb_wr_i && !txb_lock_ff;
		if (tx_ok_i) begin
			tx_run_ff <= 1'b0;
			tx_done_ff <= 1'b1;
			txb_lock_ff <= 1'b0;
		end else if (tx_start_i && tx_pend_ff) begin
			tx_pend_ff <= 1'b0;
			tx_run_ff <= 1'b1;
		end else if (c_at && tx_pend_ff && !tx_active_i) begin
			// a started frame is left to finish
			tx_pend_ff <= 1'b0;
			txb_lock_ff <= 1'b0;
		end else if (c_tr && !tx_pend_ff && !tx_run_ff) begin
			tx_pend_ff <= 1'b1;
			tx_done_ff <= 1'b0;
			txb_lock_ff <= 1'b1;
		end
		tx_pend_o <= tx_pend_ff;
	end
end

////////////////////////////////////////////////////////////////////////
// receive queue occupancy, release and overrun

reg [`CANCS_QCNT_W-1:0] qcnt_ff;
reg [`CANCS_QCNT_W-1:0] nxt_qcnt;
reg rx_avail_ff, rx_reavail_ff, ovr_ff;

always @* begin
	nxt_qcnt = qcnt_ff;
	if (rx_store_i && qcnt_ff != `CANCS_QCNT_MAX)
		nxt_qcnt = nxt_qcnt + 6'h01;
	if (c_rrb && qcnt_ff != 6'h00)
		nxt_qcnt = nxt_qcnt - 6'h01;
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		qcnt_ff <= 6'h00;
		rx_avail_ff <= 1'b0;
		rx_reavail_ff <= 1'b0;
		ovr_ff <= 1'b0;
		rx_release_o <= 1'b0;
		rx_irq_o <= 1'b0;
		ovr_irq_o <= 1'b0;
	end else begin
		qcnt_ff <= nxt_qcnt;
		rx_release_o <= c_rrb && qcnt_ff != 6'h00;
		rx_irq_o <= 1'b0;
		if (c_rrb) begin
			// cleared now, shown again on the next quantum only if frames remain queued
			rx_avail_ff <= 1'b0;
			rx_reavail_ff <= nxt_qcnt != 6'h00;
		end else if (rx_reavail_ff && quantum_tick_i) begin
			rx_reavail_ff <= 1'b0;
			rx_avail_ff <= 1'b1;
			rx_irq_o <= rie_i;
		end else if (rx_store_i && !rx_avail_ff && !rx_reavail_ff) begin
			rx_avail_ff <= 1'b1;
			rx_irq_o <= rie_i;
		end
		// the drop pulse arrives only for frames valid at end of frame
		// set wins over clear in the same cycle
		if (rx_drop_valid_i)
			ovr_ff <= 1'b1;
		else if (c_cdo)
			ovr_ff <= 1'b0;
		// interrupt on the rising edge only, so no repeats while set
		ovr_irq_o <= rx_drop_valid_i && !ovr_ff && oie_i;
	end
end

////////////////////////////////////////////////////////////////////////
// bus-off, recovery and error warning

reg bus_off_ff, recover_ff, warn_ff;
reg [`CANCS_RECOVER_W-1:0] frees_ff;
wire warn_now = (tec_i >= `CANCS_WARN_LIMIT) || (rec_i >= `CANCS_WARN_LIMIT);
wire off_now = tec_i > `CANCS_BUSOFF_LIMIT;
wire recov_done = recover_ff && bus_free && (frees_ff == `CANCS_RECOVER_FREES - 8'h01);

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		bus_off_ff <= 1'b0;
		recover_ff <= 1'b0;
		warn_ff <= 1'b0;
		frees_ff <= 8'h00;
		rst_req_set_o <= 1'b0;
		err_cnt_clr_o <= 1'b0;
		err_irq_o <= 1'b0;
	end else begin
		rst_req_set_o <= 1'b0;
		err_cnt_clr_o <= 1'b0;
		err_irq_o <= 1'b0;
		if (off_now && !bus_off_ff) begin
			bus_off_ff <= 1'b1;
			rst_req_set_o <= 1'b1;
			err_irq_o <= eie_i;
		end else if (bus_off_ff && !recover_ff && !rst_req_i) begin
			recover_ff <= 1'b1;
			frees_ff <= 8'h00;
		end else if (recov_done) begin
			// counters are cleared outside, so the warning drops with them
			bus_off_ff <= 1'b0;
			recover_ff <= 1'b0;
			warn_ff <= 1'b0;
			err_cnt_clr_o <= 1'b1;
			err_irq_o <= eie_i;
		end else if (recover_ff && bus_free) begin
			frees_ff <= frees_ff + 8'h01;
		end
		if (!recov_done && warn_now != warn_ff) begin
			warn_ff <= warn_now;
			err_irq_o <= eie_i;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// sleep and wake sequencing

reg [2:0] st_ff;
reg [2:0] nxt_st;
reg [`CANCS_BITCNT_W-1:0] clk_bits_ff;
reg gts_block_ff, was_rst_ff, clk_div_ff;
wire bus_busy = !bus_idle || !rx_sync_ff;
wire gts_ok = !rst_req_i && !gts_block_ff;
wire gts_refuse = c_gts1 && gts_ok && (irq_pending_i || bus_busy);
wire wake_bus = !rx_sync_ff;
wire wake_any = c_gts0 || wake_bus || !int_sync_ff;

always @* begin
	nxt_st = st_ff;
	case (st_ff)
	S_RUN: begin
		if (c_gts1 && gts_ok && !irq_pending_i && !bus_busy)
			nxt_st = S_SLEEP;
	end
	S_SLEEP: begin
		if (wake_any)
			nxt_st = S_RUN;
		else if (bit_tick_i && clk_bits_ff == `CANCS_HOST_CLOCK_OUTPUT_BITS - 4'h1)
			nxt_st = S_STOP;
	end
	S_STOP: begin
		if (wake_any)
			nxt_st = S_RUN;
	end
	default: nxt_st = S_RUN;
	endcase
end

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		st_ff <= S_RUN;
		clk_bits_ff <= 4'h0;
		gts_block_ff <= 1'b0;
		was_rst_ff <= 1'b0;
		clk_div_ff <= 1'b0;
		rx_hold_o <= 1'b0;
		wake_irq_o <= 1'b0;
		sleep_o <= 1'b0;
		osc_en_o <= 1'b1;
		host_clock_output_o <= 1'b0;
	end else begin
		st_ff <= nxt_st;
		was_rst_ff <= rst_req_i;
		if (rst_req_i)
			gts_block_ff <= 1'b0;
		else if (was_rst_ff)
			gts_block_ff <= 1'b1;
		else if (bus_free)
			gts_block_ff <= 1'b0;
		if (st_ff == S_RUN)
			clk_bits_ff <= 4'h0;
		else if (st_ff == S_SLEEP && bit_tick_i)
			clk_bits_ff <= clk_bits_ff + 4'h1;
		// wake interrupt on refusal and on leaving sleep
		wake_irq_o <= gts_refuse || (st_ff != S_RUN && nxt_st == S_RUN);
		if (st_ff != S_RUN && nxt_st == S_RUN && wake_bus)
			rx_hold_o <= 1'b1;
		else if (bus_free)
			rx_hold_o <= 1'b0;
		sleep_o <= nxt_st != S_RUN;
		osc_en_o <= nxt_st != S_STOP;
		clk_div_ff <= ~clk_div_ff;
		// held low once stopped; the host clocked from it has had time to park
		host_clock_output_o <= (nxt_st != S_STOP) && ~clk_div_ff;
	end
end

////////////////////////////////////////////////////////////////////////
// read port, data one cycle after the strobe

wire [7:0] status_word;
assign status_word[`CANCS_ST_BUS_OFF] = bus_off_ff;
assign status_word[`CANCS_ST_ERR_WARN] = warn_ff;
assign status_word[`CANCS_ST_TX_ACT] = tx_active_i;
assign status_word[`CANCS_ST_RX_ACT] = rx_active_i;
assign status_word[`CANCS_ST_TX_DONE] = tx_done_ff;
assign status_word[`CANCS_ST_TXB_FREE] = ~txb_lock_ff;
assign status_word[`CANCS_ST_OVERRUN] = ovr_ff;
assign status_word[`CANCS_ST_RX_AVAIL] = rx_avail_ff;

always @(posedge clock_i or negedge rstn_i) begin
	if (!rstn_i) begin
		rdata_o <= `CANCS_UNMAPPED_READ;
	end else if (rd_i) begin
		if (addr_i == `CANCS_ADDR_CMD)
			rdata_o <= `CANCS_CMD_READ;
		else if (addr_i == `CANCS_ADDR_STAT)
			rdata_o <= status_word;
		else
			rdata_o <= `CANCS_UNMAPPED_READ;
	end else begin
		rdata_o <= `CANCS_UNMAPPED_READ;
	end
end

endmodule

// ### cancs_core_checker.sv
`include "cancs_regs.vh"

module cancs_core_checker (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [`CANCS_ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic irq_pending_i,
	input wire logic rst_req_i,
	input wire logic [`CANCS_ECNT_W-1:0] tec_i,
	input wire logic [`CANCS_ECNT_W-1:0] rec_i,
	input wire logic tx_start_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i,
	input wire logic rx_drop_valid_i,
	input wire logic oie_i,
	input wire logic eie_i,
	input wire logic ovr_irq_o,
	input wire logic err_cnt_clr_o,
	input wire logic err_irq_o,
	input wire logic tx_pend_o,
	input wire logic rst_req_set_o,
	input wire logic wake_irq_o,
	input wire logic sleep_o,
	input wire logic osc_en_o,
	input wire logic host_clock_output_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	////////////////////////////////////////////////////////////
	sequence s_wcmd(b);
		wr_i && addr_i == `CANCS_ADDR_CMD && wdata_i[b];
	endsequence
	sequence s_rstat;
		rd_i && addr_i == `CANCS_ADDR_STAT;
	endsequence
	////////////////////////////////////////////////////////////
	property p_cmd_ff;
		rd_i && addr_i == `CANCS_ADDR_CMD |=> rdata_o == 8'hff;
	endproperty
	a_cmd_ff: assert property (p_cmd_ff) else $error("command read not all ones");
	property p_act;
		s_rstat |=> rdata_o[5:4] == $past({tx_active_i, rx_active_i});
	endproperty
	a_act: assert property (p_act) else $error("activity flags wrong");
	// warning lags its inputs by one cycle, so only stable counters are judged
	property p_warn;
		s_rstat ##0 ($stable(tec_i) && $stable(rec_i)) |=> rdata_o[6] == $past(tec_i >= 9'h060 || rec_i >= 9'h060);
	endproperty
	a_warn: assert property (p_warn) else $error("warning flag wrong");
	property p_tr;
		s_wcmd(0) ##0 (!tx_pend_o && !tx_active_i) ##2 s_rstat |=> rdata_o[3:2] == 2'b00;
	endproperty
	a_tr: assert property (p_tr) else $error("request left done or free set");
	property p_pend;
		s_wcmd(0) ##0 (!wdata_i[1] && !tx_pend_o && !tx_active_i && !rst_req_i && !sleep_o) |-> ##2 tx_pend_o;
	endproperty
	a_pend: assert property (p_pend) else $error("request not pending");
	property p_abort;
		s_wcmd(1) ##0 (tx_pend_o && !tx_active_i && !tx_start_i && !wdata_i[0]) |-> ##2 !tx_pend_o;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not cancel");
	property p_refuse;
		s_wcmd(4) ##0 (irq_pending_i && !sleep_o && !rst_req_i) |=> wake_irq_o && !sleep_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused sleep without wake irq");
	property p_sleep_rr;
		s_wcmd(4) ##0 (rst_req_i && !sleep_o) |-> ##2 !sleep_o;
	endproperty
	a_sleep_rr: assert property (p_sleep_rr) else $error("slept in reset mode");
	property p_clk_low;
		!osc_en_o |-> !host_clock_output_o;
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("clock output not low");
	property p_busoff;
		$rose(tec_i > 9'h0ff) && !rst_req_i |-> ##[1:2] rst_req_set_o;
	endproperty
	a_busoff: assert property (p_busoff) else $error("no reset request on bus-off");
	property p_ovr_irq;
		ovr_irq_o |-> $past(rx_drop_valid_i && oie_i);
	endproperty
	a_ovr_irq: assert property (p_ovr_irq) else $error("overrun irq without lost frame");
	property p_clr_irq;
		err_cnt_clr_o |-> err_irq_o == $past(eie_i);
	endproperty
	a_clr_irq: assert property (p_clr_irq) else $error("recovery without error irq");
endmodule

bind cancs_core cancs_core_checker u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_pending_i(irq_pending_i),
	.rst_req_i(rst_req_i), .tec_i(tec_i), .rec_i(rec_i), .tx_start_i(tx_start_i), .tx_active_i(tx_active_i),
	.rx_active_i(rx_active_i), .rx_drop_valid_i(rx_drop_valid_i), .oie_i(oie_i), .eie_i(eie_i),
	.ovr_irq_o(ovr_irq_o), .err_cnt_clr_o(err_cnt_clr_o), .err_irq_o(err_irq_o),
	.tx_pend_o(tx_pend_o), .rst_req_set_o(rst_req_set_o), .wake_irq_o(wake_irq_o),
	.sleep_o(sleep_o), .osc_en_o(osc_en_o), .host_clock_output_o(host_clock_output_o));

// ### cancs_host.sv
module cancs_host (
	input wire logic clock_i,
	output logic [4:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr_o = 5'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// released data is inverted so a stale byte never looks valid
	task wr_reg(input logic [4:0] a, input logic [7:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clock_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		@(posedge clock_i);
	endtask
	task rd_reg(input logic [4:0] a);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clock_i);
		rd_o <= 1'b0;
	endtask
endmodule

// ### cancs_core_tb.sv
`include "cancs_regs.vh"

module cancs_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 0, rstn_i = 0, rd_q = 0;
	logic bit_tick = 0, q_tick = 0, can_rx = 1, int_n = 1, irq_p = 0, rst_req = 0;
	logic eie = 1, rie = 1, oie = 1, tx_start = 0, tx_ok = 0, tx_act = 0, rx_act = 0;
	logic rx_store = 0, rx_drop = 0, txb_wr = 0;
	logic [8:0] tec = 0, rec = 0, t, r;
	logic [4:0] addr;
	logic [7:0] wdata, rdata_o;
	logic wr, rd, txb_we_o, tx_pend_o, rx_hold_o, sleep_o, osc_en_o;
	logic [7:0] q[$];
	int n_fail = 0, tests_run = 0, seed;
	initial forever #2 clock_i = ~clock_i;
	cancs_host u_host (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	cancs_core u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata_o), .bit_tick_i(bit_tick), .quantum_tick_i(q_tick), .can_rx_i(can_rx),
		.int_n_pin_i(int_n), .irq_pending_i(irq_p), .rst_req_i(rst_req), .eie_i(eie), .rie_i(rie),
		.oie_i(oie), .tec_i(tec), .rec_i(rec), .tx_start_i(tx_start), .tx_ok_i(tx_ok), .tx_active_i(tx_act),
		.rx_active_i(rx_act), .rx_store_i(rx_store), .rx_drop_valid_i(rx_drop), .txb_wr_i(txb_wr),
		.txb_we_o(txb_we_o), .tx_pend_o(tx_pend_o), .rx_release_o(), .rx_hold_o(rx_hold_o),
		.rst_req_set_o(), .err_cnt_clr_o(), .wake_irq_o(), .err_irq_o(), .rx_irq_o(), .ovr_irq_o(),
		.sleep_o(sleep_o), .osc_en_o(osc_en_o), .host_clock_output_o());
	////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tally_and_finish;
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task tick(input int n);
		repeat (n) begin
			bit_tick <= 1;
			cyc(1);
			bit_tick <= 0;
			cyc(1);
		end
	endtask
	task rdx(input logic [4:0] a, input logic [7:0] e);
		q.push_back(e);
		u_host.rd_reg(a);
	endtask
	task wc(input logic [7:0] d);
		u_host.wr_reg(`CANCS_ADDR_CMD, d);
	endtask
	////////////////////////////////////////////////////////////
	// read data stands only in the cycle after the strobe
	always @(posedge clock_i) rd_q <= rd;
	always @(negedge clock_i) if (rd_q === 1'b1) chk("rdata", q.pop_front(), rdata_o);
	initial begin
		#100000;
		n_fail++;
		tally_and_finish;
	end
	initial begin
		seed = $urandom(32'hfbe6);
		cyc(10);
		rstn_i <= 1;
		cyc(2);
		rdx(2, 8'h0c);
		rdx(1, 8'hff);
		rdx(5'h05, 8'h00);
		wc(8'h01);
		rdx(2, 8'h00);
		wc(8'h00);
		cyc(3);
		chk("pend", 1, tx_pend_o);
		txb_wr <= 1;
		cyc(1);
		txb_wr <= 0;
		#1 chk("txb_we", 0, txb_we_o);
		tx_start <= 1;
		tx_act <= 1;
		cyc(1);
		tx_start <= 0;
		wc(8'h02);
		rdx(2, 8'h20);
		tx_act <= 0;
		tx_ok <= 1;
		cyc(1);
		tx_ok <= 0;
		cyc(1);
		rdx(2, 8'h0c);
		wc(8'h01);
		wc(8'h02);
		cyc(3);
		rdx(2, 8'h04);
		rx_drop <= 1;
		cyc(1);
		rx_drop <= 0;
		cyc(1);
		rdx(2, 8'h06);
		wc(8'he0);
		rdx(2, 8'h06);
		rx_store <= 1;
		cyc(2);
		rx_store <= 0;
		q_tick <= 1;
		cyc(1);
		q_tick <= 0;
		wc(8'h0c);
		rdx(2, 8'h04);
		q_tick <= 1;
		cyc(1);
		q_tick <= 0;
		cyc(1);
		rdx(2, 8'h05);
		wc(8'h04);
		q_tick <= 1;
		cyc(1);
		q_tick <= 0;
		rdx(2, 8'h04);
		repeat (6) begin
			t = 9'($urandom_range(0, 200));
			r = 9'($urandom_range(0, 127));
			tec <= t;
			rec <= r;
			cyc(2);
			rdx(2, {1'b0, (t >= 9'h060 || r >= 9'h060), 6'h04});
		end
		tec <= 9'h12c;
		cyc(3);
		rdx(2, 8'hc4);
		rst_req <= 1;
		wc(8'h10);
		cyc(2);
		chk("sleep", 0, sleep_o);
		tec <= 0;
		rec <= 0;
		rst_req <= 0;
		tick(1600);
		rdx(2, 8'h04);
		irq_p <= 1;
		wc(8'h10);
		chk("sleep", 0, sleep_o);
		irq_p <= 0;
		wc(8'h10);
		cyc(2);
		chk("sleep", 1, sleep_o);
		tick(14);
		chk("osc", 1, osc_en_o);
		tick(2);
		chk("osc", 0, osc_en_o);
		wc(8'h00);
		cyc(2);
		chk("sleep", 0, sleep_o);
		wc(8'h10);
		can_rx <= 0;
		cyc(6);
		chk("sleep", 0, sleep_o);
		chk("hold", 1, rx_hold_o);
		can_rx <= 1;
		tick(9);
		chk("hold", 1, rx_hold_o);
		tick(5);
		chk("hold", 0, rx_hold_o);
		wc(8'h10);
		int_n <= 0;
		cyc(6);
		chk("sleep", 0, sleep_o);
		int_n <= 1;
		cyc(3);
		tally_and_finish;
	end
endmodule
